// file: hw/tsfs_defines.svh
`ifndef TSFS_DEFINES_SVH
`define TSFS_DEFINES_SVH
// ----------------------------------------
// register map and fields
// ----------------------------------------
`define TSFS_ADDR_W 8
`define TSFS_OFS_CTRL 8'h00
`define TSFS_OFS_STAT 8'h04
`define TSFS_OFS_TRIM 8'h08
`define TSFS_OFS_FAIL 8'h0C
`define TSFS_CTRL_RST 8'h38
`define TSFS_IRCF_RST 4'h7
`define TSFS_CTRL_PLL 7
`define TSFS_IRCF_HI 6
`define TSFS_IRCF_LO 3
`define TSFS_STAT_STARTUP_DONE_STATUS 5
`define TSFS_FAIL_FLAG 0
`define TSFS_FAIL_IE 1
// ----------------------------------------
// oscillator modes of the configuration word and source select codes
// ----------------------------------------
`define TSFS_MODE_LP 3'h0
`define TSFS_MODE_XT 3'h1
`define TSFS_MODE_HS 3'h2
`define TSFS_MODE_EC 3'h3
`define TSFS_MODE_INT 3'h4
`define TSFS_MODE_RC 3'h7
`define TSFS_SCS_CFG 2'h0
`define TSFS_SCS_T1 2'h1
// ----------------------------------------
// timing counts
// ----------------------------------------
`define TSFS_OST_CYCLES 11'h400
`define TSFS_SAMP_DIV 6'h20
`endif

// file: hw/tsfs_pkg.sv
package tsfs_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    TSFS_ST_INT,
    TSFS_ST_OST,
    TSFS_ST_ALIGN,
    TSFS_ST_HOLD,
    TSFS_ST_EXT,
    TSFS_ST_FAILSAFE,
    TSFS_ST_SLEEP
  } tsfs_state_e;
  // system clock source driven to the clock mux
  typedef enum logic [1:0] {
    TSFS_SRC_INT,
    TSFS_SRC_EXT,
    TSFS_SRC_T1,
    TSFS_SRC_HOLD
  } tsfs_src_e;
endpackage

// file: hw/tsfs_clock_ctrl.sv
`include "tsfs_defines.svh"
// ----------------------------------------
// Overview of operation
// R1: after reset or wake in two-speed mode, run from internal osc at selected frequency
// R2: startup timer counts 1024 external clock cycles
// R3: on expiry wait internal falling edge, set done, hold low to external fall
// R4: startup done status bit 5 is 1 on configured clock, 0 on internal; the code leaves it 0 after a select change back to EC or RC
// R5: fail monitor enabled by configuration bit, for every external mode
// R6: fail monitor inactive until the startup timer has expired
// R7: sample clock is low-frequency internal osc divided by 64
// R8: detector latch set on external fall, cleared on sample rise
// R9: failure when a whole sample half-cycle passes without external low
// R10: on failure switch to internal, set fail flag, interrupt if enabled
// R11: stay internal after failover until firmware switches back
// R12: failover frequency is the internal frequency select field
// R13: fail-safe cleared by reset, sleep, or changing source select; a change into a timer restart clears it only when that restart ends
// R14: source select change restarts startup timer, then back to external
// R15: fail flag cannot be cleared while fail-safe is active
// R16: external clock and RC modes skip the timer, monitor active at once
// R17: fail monitor enable also enables two-speed start-up
// R18: configuration PLL force overrides software PLL enable
// R19: 4-bit frequency select, resets to 0111
// R20: source select 1x internal, 01 timer1, 00 configured oscillator
// R21: status reports timer1, PLL, internal osc ready, locked, stable
// R22: six-bit two's complement trim, upper two bits read zero
// R23: two-speed only with switchover bit, select 00 and a crystal mode; the code also enables it with the monitor bit alone
// R24: sleep during start-up aborts the timer and leaves done clear
// R25: pin clocks are synchronised before affecting mux or status
// ----------------------------------------
module tsfs_clock_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] cfg_osc_mode,
  input wire logic cfg_fail_monitor_enable,
  input wire logic cfg_two_speed_enable,
  input wire logic cfg_pll_force,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic ext_clk,
  input wire logic int_osc_clk,
  input wire logic lf_osc_clk,
  input wire logic [6:0] osc_status_pins,
  output tsfs_pkg::tsfs_src_e sys_clk_src,
  output logic [3:0] internal_freq_select,
  output logic [5:0] freq_trim,
  output logic pll_enable,
  output logic osc_fail_irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] clk_meta_q, clk_sync_q, clk_prev_q;
  logic [6:0] stat_meta_q, stat_sync_q;
  logic ext_fall, int_fall, lf_rise;

  // two flops on every pin clock and status pin, then an edge history flop on the pin clocks only [R25]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_meta_q <= 3'h0;
      clk_sync_q <= 3'h0;
      clk_prev_q <= 3'h0;
      stat_meta_q <= 7'h00;
      stat_sync_q <= 7'h00;
    end else begin
      clk_meta_q <= {lf_osc_clk, int_osc_clk, ext_clk};
      clk_sync_q <= clk_meta_q;
      clk_prev_q <= clk_sync_q;
      stat_meta_q <= osc_status_pins;
      stat_sync_q <= stat_meta_q;
    end
  end

  assign ext_fall = clk_prev_q[0] & ~clk_sync_q[0];
  assign int_fall = clk_prev_q[1] & ~clk_sync_q[1];
  assign lf_rise = ~clk_prev_q[2] & clk_sync_q[2];

  // ----------------------------------------
  // registers written by software
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [5:0] trim_q;
  logic fail_ie_q;
  logic wr_en, rd_setup, scs_change;
  logic [1:0] scs_new;

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign scs_new = pwdata[1:0];
  assign scs_change = wr_en && paddr == `TSFS_OFS_CTRL && scs_new != ctrl_q[1:0];

  // control: pll enable, frequency select (reset 0111), source select [R19] [R20]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TSFS_CTRL_RST;
    end else if (wr_en && paddr == `TSFS_OFS_CTRL) begin
      ctrl_q <= {pwdata[7:3], 1'b0, pwdata[1:0]};
    end
  end

  // trim and fail interrupt enable [R22]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= 6'h00;
      fail_ie_q <= 1'b0;
    end else if (wr_en && paddr == `TSFS_OFS_TRIM) begin
      trim_q <= pwdata[5:0];
    end else if (wr_en && paddr == `TSFS_OFS_FAIL) begin
      fail_ie_q <= pwdata[`TSFS_FAIL_IE];
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic logic is_crystal(input logic [2:0] m);
    is_crystal = m == `TSFS_MODE_LP || m == `TSFS_MODE_XT || m == `TSFS_MODE_HS;
  endfunction

  logic two_speed;
  // monitor enable forces two-speed on [R17] [R23]
  assign two_speed = cfg_two_speed_enable | cfg_fail_monitor_enable;

  // ----------------------------------------
  // sample clock divider and fail detector
  // ----------------------------------------
  logic [5:0] div_q;
  logic samp_q, samp_rise, samp_fall;

  // toggle every 32 low-frequency rises, a period of 64 cycles [R7]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h00;
      samp_q <= 1'b0;
    end else if (lf_rise) begin
      if (div_q == `TSFS_SAMP_DIV - 6'h01) begin
        div_q <= 6'h00;
        samp_q <= ~samp_q;
      end else begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  assign samp_rise = lf_rise && div_q == `TSFS_SAMP_DIV - 6'h01 && !samp_q;
  assign samp_fall = lf_rise && div_q == `TSFS_SAMP_DIV - 6'h01 && samp_q;

  tsfs_pkg::tsfs_state_e state_q;
  logic latch_q, armed_q, mon_active, fail_det;

  // monitor watches only a running external clock after the timer [R5] [R6]
  assign mon_active = cfg_fail_monitor_enable && state_q == tsfs_pkg::TSFS_ST_EXT;

  // external fall sets, sample rise clears; a fall wins a tie [R8]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      if (ext_fall) begin
        latch_q <= 1'b1;
      end else if (samp_rise) begin
        latch_q <= 1'b0;
      end
      if (!mon_active) begin
        armed_q <= 1'b0;
      end else if (samp_rise) begin
        armed_q <= 1'b1;
      end
    end
  end

  // whole high half of the sample clock with no external low [R9]
  assign fail_det = mon_active && armed_q && samp_fall && !latch_q && !ext_fall;

  // ----------------------------------------
  // start-up timer and clock sequencer
  // ----------------------------------------
  logic [10:0] ost_q;
  logic ost_done, failsafe_q, startup_done_status_q;
  tsfs_pkg::tsfs_state_e restart;
  logic [1:0] scs_eff;

  assign ost_done = ext_fall && ost_q == `TSFS_OST_CYCLES - 11'h001;
  assign scs_eff = scs_change ? scs_new : ctrl_q[1:0];

  // entry state for reset, wake and source changes [R16] [R20]
  always_comb begin
    if (scs_eff[1]) begin
      restart = tsfs_pkg::TSFS_ST_INT;
    end else if (scs_eff == `TSFS_SCS_T1) begin
      restart = tsfs_pkg::TSFS_ST_EXT;
    end else if (is_crystal(cfg_osc_mode)) begin
      restart = tsfs_pkg::TSFS_ST_OST;
    end else if (cfg_osc_mode == `TSFS_MODE_INT) begin
      restart = tsfs_pkg::TSFS_ST_INT;
    end else begin
      restart = tsfs_pkg::TSFS_ST_EXT;
    end
  end

  // count 1024 external cycles while in the timer state [R2]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_q <= 11'h000;
    end else if (state_q != tsfs_pkg::TSFS_ST_OST || scs_change) begin
      ost_q <= 11'h000;
    end else if (ext_fall) begin
      ost_q <= ost_q + 11'h001;
    end
  end

  // sequencer: start-up, switchover, failover and sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tsfs_pkg::TSFS_ST_OST;
    end else if (sleep_req) begin
      state_q <= tsfs_pkg::TSFS_ST_SLEEP; // [R24]
    end else if (scs_change) begin
      state_q <= restart; // [R14]
    end else begin
      case (state_q)
        tsfs_pkg::TSFS_ST_SLEEP: begin
          if (wake_req) begin
            state_q <= restart;
          end
        end
        tsfs_pkg::TSFS_ST_OST: begin
          if (restart != tsfs_pkg::TSFS_ST_OST) begin
            state_q <= restart;
          end else if (ost_done) begin
            state_q <= tsfs_pkg::TSFS_ST_ALIGN; // [R3]
          end
        end
        tsfs_pkg::TSFS_ST_ALIGN: begin
          if (int_fall) begin
            state_q <= tsfs_pkg::TSFS_ST_HOLD; // [R3]
          end
        end
        tsfs_pkg::TSFS_ST_HOLD: begin
          if (ext_fall) begin
            state_q <= tsfs_pkg::TSFS_ST_EXT; // [R3]
          end
        end
        tsfs_pkg::TSFS_ST_EXT: begin
          if (fail_det) begin
            state_q <= tsfs_pkg::TSFS_ST_FAILSAFE; // [R10]
          end
        end
        default: begin
          state_q <= state_q; // failsafe stays until a select change or sleep [R11]
        end
      endcase
    end
  end

  // fail-safe condition: set on failure, cleared by sleep, a select change that skips the timer, or end of restart [R13] [R14]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      failsafe_q <= 1'b0;
    end else if (fail_det) begin
      failsafe_q <= 1'b1;
    end else if (sleep_req || (scs_change && restart != tsfs_pkg::TSFS_ST_OST)) begin
      failsafe_q <= 1'b0;
    end else if (state_q == tsfs_pkg::TSFS_ST_HOLD && ext_fall) begin
      failsafe_q <= 1'b0;
    end
  end

  // done status set at the internal falling edge or on reset or wake into a direct mode, cleared by sleep, failure or a select change [R4]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_done_status_q <= 1'b0;
    end else if (sleep_req || scs_change || fail_det) begin
      startup_done_status_q <= 1'b0; // [R24]
    end else if (state_q == tsfs_pkg::TSFS_ST_ALIGN && int_fall) begin
      startup_done_status_q <= 1'b1; // [R3]
    end else if (state_q == tsfs_pkg::TSFS_ST_SLEEP && wake_req) begin
      startup_done_status_q <= restart == tsfs_pkg::TSFS_ST_EXT && ctrl_q[1:0] == `TSFS_SCS_CFG;
    end else if (state_q == tsfs_pkg::TSFS_ST_OST && restart == tsfs_pkg::TSFS_ST_EXT) begin
      startup_done_status_q <= ctrl_q[1:0] == `TSFS_SCS_CFG;
    end
  end

  // ----------------------------------------
  // fail flag and interrupt
  // ----------------------------------------
  logic fail_flag_q;

  // set wins over a clear; no clear while fail-safe is active [R10] [R15]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_flag_q <= 1'b0;
    end else if (fail_det) begin
      fail_flag_q <= 1'b1;
    end else if (wr_en && paddr == `TSFS_OFS_FAIL && pwdata[`TSFS_FAIL_FLAG] && !failsafe_q) begin
      fail_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs to the clock tree
  // ----------------------------------------
  // internal during two-speed and failover, held low from the internal fall to the external fall [R1] [R12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_src <= tsfs_pkg::TSFS_SRC_HOLD;
      internal_freq_select <= `TSFS_IRCF_RST;
      freq_trim <= 6'h00;
      pll_enable <= 1'b0;
      osc_fail_irq <= 1'b0;
    end else begin
      case (state_q)
        tsfs_pkg::TSFS_ST_OST: begin
          sys_clk_src <= two_speed ? tsfs_pkg::TSFS_SRC_INT : tsfs_pkg::TSFS_SRC_HOLD;
        end
        tsfs_pkg::TSFS_ST_ALIGN: begin
          sys_clk_src <= two_speed ? tsfs_pkg::TSFS_SRC_INT : tsfs_pkg::TSFS_SRC_HOLD;
        end
        tsfs_pkg::TSFS_ST_EXT: begin
          sys_clk_src <= ctrl_q[1:0] == `TSFS_SCS_T1 ? tsfs_pkg::TSFS_SRC_T1
                                                      : tsfs_pkg::TSFS_SRC_EXT;
        end
        tsfs_pkg::TSFS_ST_INT: begin
          sys_clk_src <= tsfs_pkg::TSFS_SRC_INT;
        end
        tsfs_pkg::TSFS_ST_FAILSAFE: begin
          sys_clk_src <= tsfs_pkg::TSFS_SRC_INT; // [R10] [R11]
        end
        default: begin
          sys_clk_src <= tsfs_pkg::TSFS_SRC_HOLD;
        end
      endcase
      internal_freq_select <= ctrl_q[`TSFS_IRCF_HI:`TSFS_IRCF_LO]; // [R12]
      freq_trim <= trim_q; // [R22]
      pll_enable <= cfg_pll_force | ctrl_q[`TSFS_CTRL_PLL]; // [R18]
      osc_fail_irq <= fail_flag_q & fail_ie_q; // [R10]
    end
  end

  // ----------------------------------------
  // apb slave: zero wait, read data captured in setup
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (rd_setup) begin
        pslverr <= 1'b0;
        if (paddr == `TSFS_OFS_CTRL) begin
          prdata <= {24'h000000, ctrl_q};
        end else if (paddr == `TSFS_OFS_STAT) begin
          // synchronised status pins read as they are, with done status inserted at bit 5 [R21]
          prdata <= {24'h000000, stat_sync_q[6:5], startup_done_status_q, stat_sync_q[4:0]};
        end else if (paddr == `TSFS_OFS_TRIM) begin
          prdata <= {26'h0, trim_q}; // [R22]
        end else if (paddr == `TSFS_OFS_FAIL) begin
          prdata <= {30'h0, fail_ie_q, fail_flag_q};
        end else begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_ost_full_count: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    state_q == tsfs_pkg::TSFS_ST_ALIGN && $past(state_q) == tsfs_pkg::TSFS_ST_OST
    |-> $past(ost_q) == `TSFS_OST_CYCLES - 11'h001)
    else $error("startup timer ended early");
  a_done_at_align: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    state_q == tsfs_pkg::TSFS_ST_ALIGN && int_fall && !sleep_req && !scs_change
    |=> startup_done_status_q && state_q == tsfs_pkg::TSFS_ST_HOLD)
    else $error("done status not set at internal edge");
  a_hold_low: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
    state_q == tsfs_pkg::TSFS_ST_HOLD |=> sys_clk_src != tsfs_pkg::TSFS_SRC_EXT)
    else $error("external clock selected before its edge");
  a_mon_idle: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
    state_q == tsfs_pkg::TSFS_ST_OST |-> !fail_det)
    else $error("failure detected during start-up");
  a_fail_switch: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    fail_det && !sleep_req && !scs_change
    |=> fail_flag_q ##1 sys_clk_src == tsfs_pkg::TSFS_SRC_INT)
    else $error("failover did not switch to internal");
  a_flag_kept: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    failsafe_q && fail_flag_q |=> fail_flag_q)
    else $error("fail flag cleared during fail-safe");
  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    osc_fail_irq |-> $past(fail_flag_q) && $past(fail_ie_q))
    else $error("interrupt without enabled flag");
  a_pll_force: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    cfg_pll_force ##1 1'b1 |-> pll_enable)
    else $error("pll not forced on");
  a_sleep_abort: assert property (@(posedge pclk) disable iff (!presetn) // [R24]
    sleep_req |=> !startup_done_status_q && state_q == tsfs_pkg::TSFS_ST_SLEEP)
    else $error("sleep did not abort start-up");
endmodule // tsfs_clock_ctrl

// file: sim/tsfs_ext_osc.sv
// ----------------------------------------
// external crystal or clock at the oscillator pin
// ----------------------------------------
module tsfs_ext_osc #(
  parameter int HALF = 20
) (
  input wire logic run,
  output logic ext_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // toggles while running; a stopped oscillator parks high, so no falling edge is seen
  initial begin
    ext_clk = 1'b1;
    forever begin
      #(HALF);
      ext_clk = run ? ~ext_clk : 1'b1;
    end
  end
endmodule // tsfs_ext_osc

// file: sim/tb_two_speed_startup_fail_safe_clock.sv
`include "tsfs_defines.svh"
module tb_two_speed_startup_fail_safe_clock;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 90000;
  localparam logic [7:0] CTRL = `TSFS_OFS_CTRL;
  localparam logic [7:0] STAT = `TSFS_OFS_STAT;
  localparam logic [7:0] TRIM = `TSFS_OFS_TRIM;
  localparam logic [7:0] FAIL = `TSFS_OFS_FAIL;
  localparam tsfs_pkg::tsfs_src_e S_INT = tsfs_pkg::TSFS_SRC_INT;
  localparam tsfs_pkg::tsfs_src_e S_EXT = tsfs_pkg::TSFS_SRC_EXT;
  localparam tsfs_pkg::tsfs_src_e S_T1 = tsfs_pkg::TSFS_SRC_T1;
  localparam tsfs_pkg::tsfs_src_e S_HOLD = tsfs_pkg::TSFS_SRC_HOLD;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] cfg_osc_mode;
  logic cfg_fail_monitor_enable, cfg_two_speed_enable, cfg_pll_force;
  logic sleep_req, wake_req, ext_clk, ext_run, int_osc_clk, lf_osc_clk;
  logic pll_enable, osc_fail_irq;
  logic [6:0] osc_status_pins;
  tsfs_pkg::tsfs_src_e sys_clk_src;
  logic [3:0] internal_freq_select;
  logic [5:0] freq_trim;
  int n_errors, cmp_count, cyc;

  // ----------------------------------------
  // clocks, device and oscillator
  // ----------------------------------------
  // 200 MHz bus clock, 30 ns internal osc, 60 ns low-frequency osc
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    int_osc_clk = 1'b0;
    forever #15 int_osc_clk = ~int_osc_clk;
  end
  initial begin
    lf_osc_clk = 1'b0;
    forever #30 lf_osc_clk = ~lf_osc_clk;
  end
  tsfs_clock_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_osc_mode(cfg_osc_mode),
    .cfg_fail_monitor_enable(cfg_fail_monitor_enable),
    .cfg_two_speed_enable(cfg_two_speed_enable), .cfg_pll_force(cfg_pll_force),
    .sleep_req(sleep_req), .wake_req(wake_req), .ext_clk(ext_clk),
    .int_osc_clk(int_osc_clk), .lf_osc_clk(lf_osc_clk), .osc_status_pins(osc_status_pins),
    .sys_clk_src(sys_clk_src), .internal_freq_select(internal_freq_select),
    .freq_trim(freq_trim), .pll_enable(pll_enable), .osc_fail_irq(osc_fail_irq));
  tsfs_ext_osc #(.HALF(20)) ext_osc (.run(ext_run), .ext_clk(ext_clk));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer: setup, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register read", exp, rd);
  endtask
  task automatic wsrc(input tsfs_pkg::tsfs_src_e s, input int lim);
    int i;
    for (i = 0; i < lim && sys_clk_src !== s; i++) @(posedge pclk);
    chk("sys_clk_src", s, sys_clk_src);
  endtask
  task automatic do_reset(input logic [2:0] m, input logic ts, input logic fm);
    presetn <= 1'b0;
    cfg_osc_mode <= m;
    cfg_two_speed_enable <= ts;
    cfg_fail_monitor_enable <= fm;
    cfg_pll_force <= 1'b0;
    ext_run <= 1'b1;
    osc_status_pins <= 7'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task automatic pulse(input logic slp);
    @(posedge pclk);
    if (slp) sleep_req <= 1'b1;
    else wake_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
  // stop the oscillator after a settled external run and expect the fall-back
  task automatic fail_ext;
    repeat (800) @(posedge pclk);
    ext_run <= 1'b0;
    repeat (300) @(posedge pclk);
    chk("no early failover", S_EXT, sys_clk_src);
    wsrc(S_INT, 1200);
  endtask

  // cycle ceiling against hangs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, sleep_req, wake_req, cfg_pll_force} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    ext_run = 1'b1;
    cfg_osc_mode = `TSFS_MODE_XT;
    {cfg_two_speed_enable, cfg_fail_monitor_enable} = 2'h3;
    osc_status_pins = 7'h00;
    {n_errors, cmp_count, cyc} = 0;
    // two-speed start-up, failover and recovery in crystal mode
    do_reset(`TSFS_MODE_XT, 1'b1, 1'b1);
    chk("start source", S_INT, sys_clk_src);
    chk("freq select", 4'h7, internal_freq_select);
    rchk(CTRL, 32'h38);
    rchk(TRIM, 32'h0);
    rchk(FAIL, 32'h0);
    rchk(STAT, 32'h0);
    repeat (7000) @(posedge pclk);
    chk("timer still running", S_INT, sys_clk_src);
    wsrc(S_EXT, 3000);
    rchk(STAT, 32'h20);
    apb(1'b1, FAIL, 32'h2);
    fail_ext();
    rchk(FAIL, 32'h3);
    chk("irq", 1'b1, osc_fail_irq);
    rchk(STAT, 32'h0);
    apb(1'b1, CTRL, 32'h78);
    repeat (2) @(posedge pclk);
    chk("failover freq", 4'hF, internal_freq_select);
    apb(1'b1, FAIL, 32'h3);
    rchk(FAIL, 32'h3);
    ext_run <= 1'b1;
    repeat (500) @(posedge pclk);
    chk("stays internal", S_INT, sys_clk_src);
    apb(1'b1, CTRL, 32'h7A);
    apb(1'b1, FAIL, 32'h3);
    rchk(FAIL, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq cleared", 1'b0, osc_fail_irq);
    apb(1'b1, CTRL, 32'h78);
    repeat (100) @(posedge pclk);
    chk("timer restarted", S_INT, sys_clk_src);
    wsrc(S_EXT, 10000);
    rchk(STAT, 32'h20);
    $display("test two_speed_failover done");
    // monitor alone brings two-speed; sleep aborts start-up
    do_reset(`TSFS_MODE_HS, 1'b0, 1'b1);
    chk("monitor gives two-speed", S_INT, sys_clk_src);
    repeat (200) @(posedge pclk);
    pulse(1'b1);
    repeat (9000) @(posedge pclk);
    rchk(STAT, 32'h0);
    chk("no switch in sleep", 1'b1, sys_clk_src !== S_EXT);
    pulse(1'b0);
    wsrc(S_INT, 50);
    wsrc(S_EXT, 10000);
    $display("test sleep_abort done");
    // direct modes: no timer, monitor live at once
    for (int k = 0; k < 2; k++) begin
      do_reset(k ? `TSFS_MODE_RC : `TSFS_MODE_EC, 1'b0, 1'b1);
      wsrc(S_EXT, 50);
      rchk(STAT, 32'h20);
      fail_ext();
      rchk(FAIL, 32'h1);
      chk("irq masked", 1'b0, osc_fail_irq);
    end
    // internal mode: no timer, done stays clear, a stopped pin raises nothing
    do_reset(`TSFS_MODE_INT, 1'b0, 1'b1);
    wsrc(S_INT, 10);
    rchk(STAT, 32'h0);
    ext_run <= 1'b0;
    repeat (1600) @(posedge pclk);
    rchk(FAIL, 32'h0);
    $display("test direct_modes done");
    // registers, source select, pll and status
    do_reset(`TSFS_MODE_LP, 1'b0, 1'b0);
    chk("held low", S_HOLD, sys_clk_src);
    apb(1'b1, TRIM, 32'hFF);
    rchk(TRIM, 32'h3F);
    chk("trim port", 6'h3F, freq_trim);
    apb(1'b1, TRIM, 32'h20);
    rchk(TRIM, 32'h20);
    apb(1'b1, CTRL, 32'hFE);
    rchk(CTRL, 32'hFA);
    wsrc(S_INT, 10);
    chk("soft pll on", 1'b1, pll_enable);
    apb(1'b1, CTRL, 32'h01);
    wsrc(S_T1, 10);
    chk("low freq code", 4'h0, internal_freq_select);
    chk("soft pll off", 1'b0, pll_enable);
    cfg_pll_force <= 1'b1;
    osc_status_pins <= 7'h55;
    repeat (6) @(posedge pclk);
    chk("forced pll", 1'b1, pll_enable);
    rchk(STAT, 32'h95);
    apb(1'b1, STAT, 32'hFF);
    rchk(STAT, 32'h95);
    apb(1'b1, 8'h10, 32'hFF);
    chk("unmapped error", 1'b1, err_q);
    rchk(8'h10, 32'h0);
    rchk(CTRL, 32'h01);
    $display("test registers done");
    close_out();
  end
endmodule // tb_two_speed_startup_fail_safe_clock
